// ### rtl/bus_reset_pwr_ctrl.sv
`timescale 1ns/1ps
// Contract
// RULE1 - all bus-side inputs are sampled on the rising edge of the bus clock.
// RULE2 - bus reset without suspend floats every output and clears every register.
// RULE3 - while bus reset is held the block does nothing and drives no switch activity.
// RULE4 - after a normal reset the block comes up in its default state.
// RULE5 - bus reset together with suspend keeps every register at its current value.
// RULE6 - bus reset together with suspend still floats every output.
// RULE7 - two output lines select the card main supply rail voltage.
// RULE8 - two output lines select the card programming rail voltage.
// RULE9 - both pairs follow software settings and read power-off after a clearing reset.
module bus_reset_pwr_ctrl (
  // clock and power-up reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bus reset and suspend, both active low
  input wire logic bus_rst_n,
  input wire logic suspend_n,
  // software socket power settings
  input wire logic pwr_wr,
  input wire logic [pwr_seq_pkg::RAIL_W-1:0] main_rail_set,
  input wire logic [pwr_seq_pkg::RAIL_W-1:0] prog_rail_set,
  // main rail switch controls
  output logic card_main_rail_sel0,
  output logic card_main_rail_sel1,
  // programming rail switch controls
  output logic card_prog_rail_sel0,
  output logic card_prog_rail_sel1,
  // output enable, low while driving
  output logic out_oe_n,
  // block is functional
  output logic active
);
  // sampled bus inputs
  logic bus_rst_r;
  logic suspend_r;
  logic wr_r;
  logic [pwr_seq_pkg::RAIL_W-1:0] main_set_r;
  logic [pwr_seq_pkg::RAIL_W-1:0] prog_set_r;

  // stored socket power settings
  logic [pwr_seq_pkg::RAIL_W-1:0] main_val;
  logic [pwr_seq_pkg::RAIL_W-1:0] prog_val;

  // sequencer
  pwr_seq_pkg::seq_state_t state_r;
  pwr_seq_pkg::seq_state_t state_nxt;

  // reset and status decode
  logic clear_w;
  logic hold_w;
  logic load_w;
  logic run_w;
  logic float_w;

  // registered switch lines, one bit per line
  wire logic [pwr_seq_pkg::RAIL_W-1:0] main_line;
  wire logic [pwr_seq_pkg::RAIL_W-1:0] prog_line;

  // sample the reset pair on the rising clock edge [RULE1]
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_rst_r <= 1'b1; // power-up counts as a bus reset
      suspend_r <= 1'b0;
    end
    else
    begin
      bus_rst_r <= ~bus_rst_n;
      suspend_r <= ~suspend_n;
    end
  end

  // sample the write strobe and codes on the same edge [RULE1]
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_r <= 1'b0;
      main_set_r <= pwr_seq_pkg::RAIL_OFF;
      prog_set_r <= pwr_seq_pkg::RAIL_OFF;
    end
    else
    begin
      wr_r <= pwr_wr;
      main_set_r <= main_rail_set;
      prog_set_r <= prog_rail_set;
    end
  end

  // reset decode; suspend turns a clearing reset into a hold
  assign clear_w = bus_rst_r & ~suspend_r; // [RULE2]
  assign hold_w = bus_rst_r & suspend_r; // [RULE5]
  assign load_w = wr_r & ~bus_rst_r; // writes ignored under reset [RULE3] [RULE9]

  // state follows the sampled reset pair; the spare code falls back to reset
  always_comb
  begin
    state_nxt = pwr_seq_pkg::ST_RESET;
    unique case (state_r)
      pwr_seq_pkg::ST_RESET,
      pwr_seq_pkg::ST_HOLD,
      pwr_seq_pkg::ST_RUN:
      begin
        if (clear_w)
          state_nxt = pwr_seq_pkg::ST_RESET; // [RULE2]
        else if (hold_w)
          state_nxt = pwr_seq_pkg::ST_HOLD; // [RULE5]
        else
          state_nxt = pwr_seq_pkg::ST_RUN; // [RULE4]
      end
      default:
        state_nxt = pwr_seq_pkg::ST_RESET;
    endcase
  end

  // sequencer state, power-up lands in reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= pwr_seq_pkg::ST_RESET;
    else
      state_r <= state_nxt;
  end

  // socket power settings survive a suspended reset
  rail_ctrl_reg #(.W(pwr_seq_pkg::RAIL_W)) u_main (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(clear_w),
    .hold(hold_w),
    .load(load_w),
    .load_val(main_set_r),
    .value_r(main_val)
  );

  rail_ctrl_reg #(.W(pwr_seq_pkg::RAIL_W)) u_prog (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(clear_w),
    .hold(hold_w),
    .load(load_w),
    .load_val(prog_set_r),
    .value_r(prog_val)
  );

  // status decode from the settled state
  assign run_w = (state_r == pwr_seq_pkg::ST_RUN);
  assign float_w = ~run_w; // switch lines float in either reset

  // one output flop per switch line, both rails side by side [RULE7] [RULE8]
  for (genvar b = 0; b < pwr_seq_pkg::RAIL_W; b++)
  begin : g_line
    logic main_q_r;
    logic prog_q_r;

    // one cycle behind the stored settings, so lines never glitch
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        main_q_r <= pwr_seq_pkg::RAIL_OFF[b];
        prog_q_r <= pwr_seq_pkg::RAIL_OFF[b];
      end
      else
      begin
        main_q_r <= main_val[b]; // [RULE7]
        prog_q_r <= prog_val[b]; // [RULE8]
      end
    end

    assign main_line[b] = main_q_r;
    assign prog_line[b] = prog_q_r;
  end

  // pairing: code bit 0 to line 0, bit 1 to line 1
  assign card_main_rail_sel0 = main_line[pwr_seq_pkg::SEL0_BIT]; // [RULE7]
  assign card_main_rail_sel1 = main_line[pwr_seq_pkg::SEL1_BIT]; // [RULE7]
  assign card_prog_rail_sel0 = prog_line[pwr_seq_pkg::SEL0_BIT]; // [RULE8]
  assign card_prog_rail_sel1 = prog_line[pwr_seq_pkg::SEL1_BIT]; // [RULE8]

  // status flops; one enable covers all switch lines
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_oe_n <= 1'b1;
      active <= 1'b0;
    end
    else
    begin
      out_oe_n <= float_w; // float in either reset [RULE2] [RULE6]
      active <= run_w; // default state after release [RULE3] [RULE4]
    end
  end
endmodule

// ### rtl/pwr_seq_pkg.sv
package pwr_seq_pkg;
  // switch control codes, two bits per rail
  localparam logic [1:0] RAIL_OFF = 2'h0;
  localparam logic [1:0] RAIL_RST = RAIL_OFF;
  localparam int RAIL_W = 2;
  localparam int SEL0_BIT = 0;
  localparam int SEL1_BIT = 1;
  // sequencer states
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN = 2'b10
  } seq_state_t;
endpackage

// ### rtl/rail_ctrl_reg.sv
`timescale 1ns/1ps
module rail_ctrl_reg #(
  parameter int W = pwr_seq_pkg::RAIL_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic hold,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // setting
  output logic [W-1:0] value_r
);
  logic [W-1:0] value_nxt;

  // hold beats load so suspended contents never change
  assign value_nxt = clear ? W'(pwr_seq_pkg::RAIL_RST) : (hold ? value_r : (load ? load_val : value_r));

  // asynchronous clear to the power-off code
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      value_r <= W'(pwr_seq_pkg::RAIL_RST);
    else
      value_r <= value_nxt;
  end
endmodule

// ### tb/bus_reset_and_card_power_control_bench.sv
`timescale 1ns/1ps
module bus_reset_and_card_power_control_bench;
  logic core_clk, rst_n, bus_rst_n, suspend_n, pwr_wr, out_oe_n, active;
  logic card_main_rail_sel0, card_main_rail_sel1, card_prog_rail_sel0, card_prog_rail_sel1;
  logic [1:0] main_rail_set, prog_rail_set;
  logic [3:0] code;
  int fails, n_checks;
  // rows: {oe_n, active, codes}; codes are the write data
  logic [5:0] rows [4] = '{6'h11, 6'h16, 6'h1B, 6'h1C};
  bus_reset_pwr_ctrl u_bus_reset_pwr_ctrl (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .bus_rst_n(bus_rst_n),
    .suspend_n(suspend_n),
    .pwr_wr(pwr_wr),
    .main_rail_set(main_rail_set),
    .prog_rail_set(prog_rail_set),
    .card_main_rail_sel0(card_main_rail_sel0),
    .card_main_rail_sel1(card_main_rail_sel1),
    .card_prog_rail_sel0(card_prog_rail_sel0),
    .card_prog_rail_sel1(card_prog_rail_sel1),
    .out_oe_n(out_oe_n),
    .active(active)
  );
  rail_sw u_rail_sw (.ctl({card_main_rail_sel1, card_main_rail_sel0, card_prog_rail_sel1, card_prog_rail_sel0}),
    .oe_n(out_oe_n), .code(code));
  // clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // outputs seen through the switch
  task chk(input logic [5:0] exp);
    n_checks++;
    if ({out_oe_n, active, code} !== exp)
    begin
      fails++;
      $display("unexpected obs: expected %h seen %h", exp, {out_oe_n, active, code});
    end
  endtask
  // drive levels and a one cycle write, then wait n edges
  task go(input logic [6:0] v, input int n);
    @(posedge core_clk);
    {bus_rst_n, suspend_n, pwr_wr, main_rail_set, prog_rail_set} <= v;
    @(posedge core_clk);
    pwr_wr <= 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task close_out;
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog, run needs under 100 cycles
  initial
  begin
    #100000;
    fails++;
    close_out;
  end
  // main sequence; suspended write must be dropped
  initial
  begin
    {rst_n, bus_rst_n, suspend_n, pwr_wr, main_rail_set, prog_rail_set} = 8'h20;
    fails = 0;
    n_checks = 0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    go(7'h60, 2);
    chk(6'h10);
    foreach (rows[i])
    begin
      go({3'h7, rows[i][3:0]}, 3);
      chk(rows[i]);
    end
    go(7'h15, 3);
    chk(6'h20);
    go(7'h60, 2);
    chk(6'h1C);
    go(7'h2F, 3); // clearing reset with the write strobe low and every code bit high still clears the settings
    chk(6'h20);
    go(7'h60, 2);
    chk(6'h10);
    go({3'h7, 4'h9}, 3);
    chk(6'h19);
    // power-up reset in mid-run drops even a live setting
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk(6'h20);
    @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(6'h10);
    close_out;
  end
endmodule

// ### tb/pwr_checker.sv
`timescale 1ns/1ps
module pwr_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bus side
  input wire logic bus_rst_n,
  input wire logic suspend_n,
  input wire logic pwr_wr,
  input wire logic [1:0] main_rail_set,
  input wire logic [1:0] prog_rail_set,
  // switch side
  input wire logic card_main_rail_sel0,
  input wire logic card_main_rail_sel1,
  input wire logic card_prog_rail_sel0,
  input wire logic card_prog_rail_sel1,
  input wire logic out_oe_n,
  input wire logic active
);
  // both codes as one word
  wire [3:0] sel = {card_main_rail_sel1, card_main_rail_sel0, card_prog_rail_sel1, card_prog_rail_sel0};
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // a write needs bus reset high through the three stage pipe
  a_write_lands: assert property (pwr_wr && active && suspend_n && bus_rst_n ##1 bus_rst_n[*2]
    |=> sel == {$past(main_rail_set, 3), $past(prog_rail_set, 3)}) else $error("write lost");
  a_clear_sel: assert property (!bus_rst_n && suspend_n |-> ##3 (sel == 4'h0)) else $error("not cleared");
  a_float_held: assert property (!bus_rst_n[*3] |=> out_oe_n) else $error("driving");
  a_idle_held: assert property (!bus_rst_n[*4] |-> !active) else $error("active");
  a_keep_sel: assert property ((!bus_rst_n && !suspend_n)[*3] |=> $stable(sel)) else $error("lost");
  a_wake_up: assert property ($rose(bus_rst_n) ##1 bus_rst_n |-> ##2 (active && !out_oe_n)) else $error("no wake");
  a_rise_cause: assert property ($rose(active) |-> $past(bus_rst_n, 3)) else $error("early");
  a_sel_cause: assert property ($changed(sel) |-> $past(pwr_wr, 3) || !$past(bus_rst_n, 3)) else $error("stray");
endmodule
bind bus_reset_pwr_ctrl pwr_checker u_pwr_checker (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .bus_rst_n(bus_rst_n),
  .suspend_n(suspend_n),
  .pwr_wr(pwr_wr),
  .main_rail_set(main_rail_set),
  .prog_rail_set(prog_rail_set),
  .card_main_rail_sel0(card_main_rail_sel0),
  .card_main_rail_sel1(card_main_rail_sel1),
  .card_prog_rail_sel0(card_prog_rail_sel0),
  .card_prog_rail_sel1(card_prog_rail_sel1),
  .out_oe_n(out_oe_n),
  .active(active)
);

// ### tb/rail_sw.sv
`timescale 1ns/1ps
// far switch model
module rail_sw (
  // controls
  input wire logic [3:0] ctl,
  input wire logic oe_n,
  // applied codes
  output logic [3:0] code
);
  // floated lines sit pulled down, so both rails read off
  assign code = oe_n ? 4'h0 : ctl;
endmodule
